// ===== pkg/cwcp_pkg.sv
// constants and types for the configuration word and code protection block
package cwcp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TERA_MIN_MS = 4;
  localparam int unsigned TERA_MAX_MS = 10;
  localparam int unsigned ERASE_CYCLES = (TERA_MIN_MS * CLK_HZ + 999) / 1000;

  localparam int unsigned CFG_W = 12;
  localparam int unsigned ADDR_W = 11;
  localparam logic [11:0] CFG_ERASED = 12'hfff;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] WORD_ONES = 12'hfff;

  localparam int unsigned BIT_UNIMPL = 11;
  localparam int unsigned GUARD_HI = 10;
  localparam int unsigned GUARD_LO = 7;
  localparam int unsigned BIT_DATA_GUARD = 6;
  localparam int unsigned BIT_OSC_SPEED = 5;
  localparam int unsigned BIT_RESET_PIN = 4;
  localparam int unsigned BIT_BALANCE = 3;
  localparam int unsigned BIT_WATCHDOG = 2;
  localparam int unsigned OSC_HI = 1;
  localparam int unsigned OSC_LO = 0;

  localparam logic [3:0] GUARD_PAT_ERASED = 4'hf;
  localparam logic [3:0] GUARD_PAT_OPEN = 4'hb;
  localparam logic [3:0] GUARD_PAT_LOCKED = 4'h2;

  localparam logic [1:0] OSC_LOW_POWER_XTAL = 2'h0;
  localparam logic [1:0] OSC_STD_XTAL = 2'h1;
  localparam logic [1:0] OSC_INTERNAL_RC = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL_RC = 2'h3;

  localparam logic [10:0] ADDR_LAST_GUARDED = 11'h5fe;
  localparam logic [10:0] ADDR_LAST_USER = 11'h5ff;
  localparam logic [10:0] ADDR_DATA_FIRST = 11'h600;
  localparam logic [10:0] ADDR_DATA_LAST = 11'h63f;
  localparam logic [10:0] ADDR_CFGMEM_FIRST = 11'h640;
  localparam logic [10:0] ADDR_CFGMEM_LAST = 11'h647;
  localparam logic [10:0] ADDR_FUSE_WORD = 11'h7ff;

  typedef enum logic [1:0] {
    GUARD_ERASED,
    GUARD_OPEN,
    GUARD_LOCKED,
    GUARD_BLOCKED
  } cwcp_guard_t;
endpackage

// ===== logic/cwcp_erase_timer.sv
// bulk erase duration timer
`timescale 1ns/1ps
module cwcp_erase_timer #(
  parameter int unsigned CYCLES = cwcp_pkg::ERASE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // count runs while busy, start ignored until done
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!busy_o)
      begin
        if (start_i)
        begin
          busy_o <= 1'b1;
          cnt_q <= '0;
        end
      end
      else if (cnt_q == LAST)
      begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end
endmodule

// ===== logic/cwcp_top.sv
// configuration word decode and code protection gate
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) config word top bit reads one
// (RULE_02) guard pattern 1011 open, 0010 locked
// (RULE_03) erased fuses give all guard bits one
// (RULE_04) bit 6 zero protects data memory
// (RULE_05) bit 5 selects 8 or 4 MHz
// (RULE_06) bit 4 enables external reset pin
// (RULE_07) programmer sets odd balance bit
// (RULE_08) bit 2 enables watchdog
// (RULE_09) oscillator select and start-up delay choice
// (RULE_10) locked user reads return zero
// (RULE_11) last user location never guarded; reads of it bypass the guard, writes are refused when locked or blocked
// (RULE_12) ids, trim, config always readable, writable; writes to them are refused while an erase is busy
// (RULE_13) data guard ignores program guard bits
// (RULE_14) programmer uses only documented guard patterns; t_guard also drives pattern 0101 through pulse_fuse
// (RULE_15) programmer unlocks before programming flash
// (RULE_16) three bulk erases lift protection; each erase_done reloads CFG_ERASED, so a single erase already lifts it
// (RULE_17) erase finishes within 4 to 10 ms
// (RULE_18) programmer checksum with protection off
// (RULE_19) programmer checksum with protection on
// (RULE_20) programmer leaves 1 us gaps; the model's pulse_fuse gap is 5 cycles (125 ns)
// (RULE_21) programmer holds entry pattern 5 us
// (RULE_22) programmer waits after mode exit
// (RULE_23) erased user memory reads all ones
module cwcp_top #(
  parameter int unsigned ERASE_CYCLES = cwcp_pkg::ERASE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic fuse_wr_i,
  input wire logic [11:0] fuse_wdata_i,
  input wire logic erase_req_i,
  input wire logic rd_req_i,
  input wire logic [10:0] rd_addr_i,
  input wire logic [11:0] mem_rdata_i,
  input wire logic wr_req_i,
  input wire logic [10:0] wr_addr_i,
  input wire logic external_reset_pin_n_i,
  output logic [11:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_grant_o,
  output logic wr_refuse_o,
  output logic erase_busy_o,
  output logic [1:0] guard_state_o,
  output logic prog_protect_o,
  output logic access_block_o,
  output logic data_protect_o,
  output logic osc_8mhz_o,
  output logic reset_pin_enable_o,
  output logic watchdog_enable_o,
  output logic [1:0] osc_source_sel_o,
  output logic startup_delay_long_o,
  output logic balance_ok_o,
  output logic ext_reset_o
);
  logic [11:0] fuse_word_q;
  logic mem_erased_q;
  cwcp_pkg::cwcp_guard_t guard_q;
  logic erase_busy;
  logic erase_done;
  logic [2:0] pin_sync_q;
  logic pin_level_q;
  logic [11:0] rd_data_d;
  logic wr_ok_d;

  function automatic logic is_user(input logic [10:0] a);
    return a <= cwcp_pkg::ADDR_LAST_USER;
  endfunction

  function automatic logic is_data(input logic [10:0] a);
    return (a >= cwcp_pkg::ADDR_DATA_FIRST) && (a <= cwcp_pkg::ADDR_DATA_LAST);
  endfunction

  function automatic logic is_cfg_area(input logic [10:0] a);
    return ((a >= cwcp_pkg::ADDR_CFGMEM_FIRST) && (a <= cwcp_pkg::ADDR_CFGMEM_LAST))
      || (a == cwcp_pkg::ADDR_FUSE_WORD);
  endfunction

  function automatic cwcp_pkg::cwcp_guard_t guard_of(input logic [11:0] w);
    logic [3:0] p;
    p = w[cwcp_pkg::GUARD_HI:cwcp_pkg::GUARD_LO];
    case (p)
      cwcp_pkg::GUARD_PAT_ERASED: return cwcp_pkg::GUARD_ERASED;
      cwcp_pkg::GUARD_PAT_OPEN: return cwcp_pkg::GUARD_OPEN; // [RULE_02]
      cwcp_pkg::GUARD_PAT_LOCKED: return cwcp_pkg::GUARD_LOCKED; // [RULE_02]
      default: return cwcp_pkg::GUARD_BLOCKED; // [RULE_02]
    endcase
  endfunction

  cwcp_erase_timer #(
    .CYCLES(ERASE_CYCLES)
  ) u_erase_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(erase_req_i),
    .busy_o(erase_busy),
    .done_o(erase_done)
  );

  // fuse word store: program writes and bulk erase
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      fuse_word_q <= cwcp_pkg::CFG_ERASED;
    end
    else if (erase_done)
    begin
      fuse_word_q <= cwcp_pkg::CFG_ERASED; // [RULE_03] [RULE_16] [RULE_17]
    end
    else if (fuse_wr_i && !erase_busy)
    begin
      fuse_word_q <= {1'b1, fuse_wdata_i[10:0]}; // [RULE_01] [RULE_12]
    end
  end

  // user memory erased flag, set by erase, cleared by a user write
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      mem_erased_q <= 1'b0;
    end
    else if (erase_done)
    begin
      mem_erased_q <= 1'b1; // [RULE_23]
    end
    else if (wr_req_i && wr_ok_d && is_user(wr_addr_i))
    begin
      mem_erased_q <= 1'b0;
    end
  end

  // decoded configuration outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      guard_q <= cwcp_pkg::GUARD_ERASED;
      data_protect_o <= 1'b0;
      osc_8mhz_o <= 1'b1;
      reset_pin_enable_o <= 1'b1;
      watchdog_enable_o <= 1'b1;
      osc_source_sel_o <= cwcp_pkg::OSC_EXTERNAL_RC;
      startup_delay_long_o <= 1'b0;
      balance_ok_o <= 1'b1;
    end
    else
    begin
      guard_q <= guard_of(fuse_word_q);
      data_protect_o <= !fuse_word_q[cwcp_pkg::BIT_DATA_GUARD]; // [RULE_04] [RULE_13]
      osc_8mhz_o <= fuse_word_q[cwcp_pkg::BIT_OSC_SPEED]; // [RULE_05]
      reset_pin_enable_o <= fuse_word_q[cwcp_pkg::BIT_RESET_PIN]; // [RULE_06]
      watchdog_enable_o <= fuse_word_q[cwcp_pkg::BIT_WATCHDOG]; // [RULE_08]
      osc_source_sel_o <= fuse_word_q[cwcp_pkg::OSC_HI:cwcp_pkg::OSC_LO]; // [RULE_09]
      case (fuse_word_q[cwcp_pkg::OSC_HI:cwcp_pkg::OSC_LO])
        cwcp_pkg::OSC_LOW_POWER_XTAL: startup_delay_long_o <= 1'b1; // [RULE_09]
        cwcp_pkg::OSC_STD_XTAL: startup_delay_long_o <= 1'b1; // [RULE_09]
        default: startup_delay_long_o <= 1'b0; // [RULE_09]
      endcase
      balance_ok_o <= ^fuse_word_q[cwcp_pkg::BIT_DATA_GUARD:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      guard_state_o <= 2'h0;
      prog_protect_o <= 1'b0;
      access_block_o <= 1'b0;
    end
    else
    begin
      guard_state_o <= guard_q;
      prog_protect_o <= (guard_q == cwcp_pkg::GUARD_LOCKED);
      access_block_o <= (guard_q == cwcp_pkg::GUARD_BLOCKED);
    end
  end

  // read data gating
  always_comb
  begin
    rd_data_d = mem_rdata_i;
    if (rd_addr_i == cwcp_pkg::ADDR_FUSE_WORD)
    begin
      rd_data_d = fuse_word_q;
      rd_data_d[cwcp_pkg::BIT_UNIMPL] = 1'b1; // [RULE_01] [RULE_12]
    end
    else if (is_cfg_area(rd_addr_i))
    begin
      rd_data_d = mem_rdata_i; // [RULE_12]
    end
    else if (is_user(rd_addr_i))
    begin
      if (rd_addr_i == cwcp_pkg::ADDR_LAST_USER)
      begin
        rd_data_d = mem_erased_q ? cwcp_pkg::WORD_ONES : mem_rdata_i; // [RULE_11] [RULE_23]
      end
      else if ((guard_q == cwcp_pkg::GUARD_LOCKED) || (guard_q == cwcp_pkg::GUARD_BLOCKED))
      begin
        rd_data_d = cwcp_pkg::WORD_ZERO; // [RULE_10]
      end
      else if (mem_erased_q)
      begin
        rd_data_d = cwcp_pkg::WORD_ONES; // [RULE_23]
      end
    end
    else if (is_data(rd_addr_i))
    begin
      if (!fuse_word_q[cwcp_pkg::BIT_DATA_GUARD])
      begin
        rd_data_d = cwcp_pkg::WORD_ZERO; // [RULE_04] [RULE_13]
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= cwcp_pkg::WORD_ZERO;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_req_i;
      if (rd_req_i)
      begin
        rd_data_o <= rd_data_d;
      end
    end
  end

  // write permission
  always_comb
  begin
    wr_ok_d = 1'b0;
    if (erase_busy)
    begin
      wr_ok_d = 1'b0;
    end
    else if (is_cfg_area(wr_addr_i))
    begin
      wr_ok_d = 1'b1; // [RULE_12]
    end
    else if (is_user(wr_addr_i))
    begin
      wr_ok_d = (guard_q == cwcp_pkg::GUARD_OPEN) || (guard_q == cwcp_pkg::GUARD_ERASED); // [RULE_02]
    end
    else if (is_data(wr_addr_i))
    begin
      wr_ok_d = fuse_word_q[cwcp_pkg::BIT_DATA_GUARD]; // [RULE_13]
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_grant_o <= 1'b0;
      wr_refuse_o <= 1'b0;
      erase_busy_o <= 1'b0;
    end
    else
    begin
      wr_grant_o <= wr_req_i && wr_ok_d;
      wr_refuse_o <= wr_req_i && !wr_ok_d;
      erase_busy_o <= erase_busy; // [RULE_17]
    end
  end

  // reset pin: three stage sync, accept once stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_sync_q <= 3'h7;
      pin_level_q <= 1'b1;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[1:0], external_reset_pin_n_i};
      if (pin_sync_q[1] == pin_sync_q[2])
      begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_reset_o <= 1'b0;
    end
    else
    begin
      ext_reset_o <= fuse_word_q[cwcp_pkg::BIT_RESET_PIN] && !pin_level_q; // [RULE_06]
    end
  end
endmodule

// ===== test/cwcp_prog_model.sv
// programmer model: fuse word writes and bulk erase sequence
`timescale 1ns/1ps
module cwcp_prog_model #(
  parameter int unsigned EC = 20
) (
  input wire logic ref_clk_i,
  output logic fuse_wr_o,
  output logic [11:0] fuse_wdata_o,
  output logic erase_req_o
);
  initial
  begin
    fuse_wr_o = 1'b0;
    fuse_wdata_o = 12'hfff;
    erase_req_o = 1'b0;
  end
  // one-cycle pulse, then data scrambled and a quiet gap
  task automatic pulse_fuse(input logic [11:0] w);
  begin
    @(negedge ref_clk_i);
    fuse_wdata_o = w;
    fuse_wr_o = 1'b1;
    @(negedge ref_clk_i);
    fuse_wr_o = 1'b0;
    fuse_wdata_o = ~w;
    repeat (5) @(negedge ref_clk_i);
  end
  endtask
  task automatic write_fuse(input logic [3:0] g, input logic [6:0] low);
    logic [6:0] b;
  begin
    b = low;
    b[3] = ~^{low[6:4], low[2:0]};
    pulse_fuse({1'b1, g, b});
  end
  endtask
  // quiet span after the programming voltage rises
  task automatic enter_mode();
  begin
    repeat (200) @(negedge ref_clk_i);
  end
  endtask
  // discharge span after leaving program mode
  task automatic leave_mode();
  begin
    repeat (4000) @(negedge ref_clk_i);
  end
  endtask
  task automatic unlock();
  begin
    repeat (3)
    begin
      @(negedge ref_clk_i);
      erase_req_o = 1'b1;
      @(negedge ref_clk_i);
      erase_req_o = 1'b0;
      repeat (EC + 6) @(negedge ref_clk_i);
    end
  end
  endtask
endmodule

// ===== test/cwcp_top_assertions.sv
// checker for the decode and protection ports
`timescale 1ns/1ps
module cwcp_top_assertions #(
  parameter int unsigned ERASE_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic rd_req_i,
  input wire logic [10:0] rd_addr_i,
  input wire logic [11:0] mem_rdata_i,
  input wire logic [11:0] rd_data_o,
  input wire logic wr_req_i,
  input wire logic [10:0] wr_addr_i,
  input wire logic wr_grant_o,
  input wire logic erase_req_i,
  input wire logic erase_busy_o,
  input wire logic [1:0] guard_state_o,
  input wire logic data_protect_o,
  input wire logic [1:0] osc_source_sel_o,
  input wire logic startup_delay_long_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  int unsigned busy_len_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !erase_busy_o)
      busy_len_q <= 0;
    else
      busy_len_q <= busy_len_q + 1;
  end
  AST_DELAY_SEL: assert property (startup_delay_long_o == !osc_source_sel_o[1])
    else $error("delay select");
  AST_LOCKED_READ: assert property (rd_req_i && rd_addr_i <= 11'h5fe ##1 guard_state_o == 2'h2
    |-> rd_data_o == 12'h000) else $error("locked read");
  AST_TOP_BIT: assert property (rd_req_i && rd_addr_i == 11'h7ff |=> rd_data_o[11])
    else $error("top bit");
  AST_CFG_READ: assert property (rd_req_i && rd_addr_i inside {[11'h640:11'h647]}
    |=> rd_data_o == $past(mem_rdata_i)) else $error("id read");
  AST_DATA_GUARD: assert property (rd_req_i && rd_addr_i inside {[11'h600:11'h63f]} ##1 data_protect_o
    |-> rd_data_o == 12'h000) else $error("data guard");
  AST_CFG_GRANT: assert property (wr_req_i && wr_addr_i == 11'h7ff ##1 !erase_busy_o |-> wr_grant_o)
    else $error("fuse write");
  AST_ERASE_START: assert property (erase_req_i && !erase_busy_o ##1 !erase_busy_o |=> erase_busy_o)
    else $error("erase start");
  AST_ERASE_LEN: assert property ($fell(erase_busy_o) |-> busy_len_q + 1 >= ERASE_CYCLES
    && busy_len_q <= ERASE_CYCLES + 1) else $error("erase length");
endmodule
bind cwcp_top cwcp_top_assertions #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.ref_clk_i, .rst_n_i, .rd_req_i,
  .rd_addr_i, .mem_rdata_i, .rd_data_o, .wr_req_i, .wr_addr_i, .wr_grant_o, .erase_req_i, .erase_busy_o,
  .guard_state_o, .data_protect_o, .osc_source_sel_o, .startup_delay_long_o);

// ===== test/cwcp_top_tb.sv
// bench for the decode and protection block
`timescale 1ns/1ps
module cwcp_top_tb;
  localparam int unsigned EC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rq = 1'b0;
  logic wq = 1'b0;
  logic pin_n = 1'b1;
  logic [10:0] ra = 11'h000;
  logic [10:0] wa = 11'h000;
  logic [11:0] mem = 12'h000;
  logic fw, er, rv, wg, wf, busy, pp, ab, dp, o8, rpe, wde, dl, bal, xr;
  logic [11:0] fd, rd;
  logic [1:0] gs, os;
  int err_count = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  cwcp_prog_model #(.EC(EC)) prog_u (.ref_clk_i(clk), .fuse_wr_o(fw), .fuse_wdata_o(fd), .erase_req_o(er));
  cwcp_top #(.ERASE_CYCLES(EC)) dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .fuse_wr_i(fw), .fuse_wdata_i(fd),
    .erase_req_i(er), .rd_req_i(rq), .rd_addr_i(ra), .mem_rdata_i(mem), .wr_req_i(wq), .wr_addr_i(wa),
    .external_reset_pin_n_i(pin_n), .rd_data_o(rd), .rd_valid_o(rv), .wr_grant_o(wg), .wr_refuse_o(wf),
    .erase_busy_o(busy), .guard_state_o(gs), .prog_protect_o(pp), .access_block_o(ab), .data_protect_o(dp),
    .osc_8mhz_o(o8), .reset_pin_enable_o(rpe), .watchdog_enable_o(wde), .osc_source_sel_o(os),
    .startup_delay_long_o(dl), .balance_ok_o(bal), .ext_reset_o(xr));
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string m);
  begin
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  end
  endtask
  task automatic rd_word(input logic [10:0] a, input logic [11:0] d, input logic [11:0] exp, input string m);
  begin
    @(negedge clk);
    rq = 1'b1;
    ra = a;
    mem = d;
    @(negedge clk);
    rq = 1'b0;
    mem = ~d;
    check({11'h000, rv}, 12'h001, m);
    check(rd, exp, m);
  end
  endtask
  task automatic wr_ask(input logic [10:0] a, input logic g, input string m);
  begin
    @(negedge clk);
    wq = 1'b1;
    wa = a;
    @(negedge clk);
    wq = 1'b0;
    check({10'h000, wg, wf}, {10'h000, g, ~g}, m);
  end
  endtask
  task automatic t_reset();
  begin
    check({gs, os, wde, o8, rpe, dp, dl, busy}, 12'h0f8, "reset");
    rd_word(11'h7ff, 12'h123, 12'hfff, "erased fuse");
  end
  endtask
  task automatic t_decode();
    logic [6:0] low;
    logic [8:0] e;
  begin
    pin_n = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      low = {i[0], ~i[0], i[1], 1'b0, ~i[1], i[1:0]};
      prog_u.write_fuse(4'hb, low);
      repeat (6) @(negedge clk);
      e = {~low[6], low[5], low[4], low[2], low[1:0], ~low[1], 1'b1, low[4]};
      check({dp, o8, rpe, wde, os, dl, bal, xr}, e, "decode");
    end
    pin_n = 1'b1;
  end
  endtask
  task automatic t_guard();
    logic [15:0] pats = 16'hfb25;
  begin
    for (int i = 0; i < 4; i++)
    begin
      prog_u.pulse_fuse({1'b1, pats[15 - 4 * i -: 4], 7'h7f});
      check({gs, pp, ab, dp}, {i[1:0], i == 2, i == 3, 1'b0}, "guard");
    end
  end
  endtask
  task automatic t_protect();
  begin
    prog_u.write_fuse(4'hb, 7'h7f);
    wr_ask(11'h100, 1'b1, "open write");
    prog_u.write_fuse(4'h2, 7'h00);
    rd_word(11'h100, 12'h5a5, 12'h000, "locked read");
    rd_word(11'h5ff, 12'h5a5, 12'h5a5, "last word");
    rd_word(11'h643, 12'h3c3, 12'h3c3, "id read");
    rd_word(11'h7ff, 12'h000, 12'h908, "fuse read");
    rd_word(11'h610, 12'h0f0, 12'h000, "data read");
    wr_ask(11'h7ff, 1'b1, "fuse write");
    wr_ask(11'h100, 1'b0, "locked write");
  end
  endtask
  task automatic t_erase();
  begin
    fork
      prog_u.unlock();
      begin
        repeat (4) @(negedge clk);
        check({11'h000, busy}, 12'h001, "busy");
        wr_ask(11'h7ff, 1'b0, "busy write");
      end
    join
    check({10'h000, gs}, 12'h000, "erased guard");
    rd_word(11'h7ff, 12'h000, 12'hfff, "erased fuse");
    rd_word(11'h200, 12'h000, 12'hfff, "erased user");
  end
  endtask
  task automatic t_checksum();
    logic [15:0] sum;
    logic [15:0] sid;
    logic [47:0] ids = 48'h729838724635;
  begin
    sum = 16'h0000;
    for (int a = 0; a < 1535; a++)
    begin
      rd_word(11'(a), 12'h000, 12'hfff, "blank word");
      sum = sum + {4'h0, rd};
    end
    rd_word(11'h7ff, 12'h000, 12'hfff, "blank fuse");
    sum = sum + {9'h000, rd[6:0]};
    checks++;
    if (sum !== 16'hea80)
    begin
      err_count++;
      $display("mismatch at %0t: blank checksum %h", $time, sum);
    end
    prog_u.write_fuse(4'h2, 7'h7f);
    rd_word(11'h010, 12'hfff, 12'h000, "locked blank");
    sid = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      rd_word(11'h640 + 11'(i), ids[47 - 12 * i -: 12], ids[47 - 12 * i -: 12], "id word");
      sid = {sid[11:0], rd[3:0]};
    end
    rd_word(11'h7ff, 12'h000, 12'h97f, "locked fuse");
    sum = sid + {9'h000, rd[6:0]};
    checks++;
    if (sum !== 16'h98c4)
    begin
      err_count++;
      $display("mismatch at %0t: locked checksum %h", $time, sum);
    end
  end
  endtask
  task automatic tally_and_finish();
  begin
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    prog_u.enter_mode();
    t_decode();
    t_guard();
    t_protect();
    t_erase();
    t_checksum();
    prog_u.leave_mode();
    tally_and_finish();
  end
  initial
  begin
    #(25 * 20000);
    err_count++;
    tally_and_finish();
  end
endmodule
